// ==== design/power_ctrl_pkg.sv ====
// Notes on behaviour
// - The bus is SMBus v1.1 with optional master mode and PEC, and both ends use that revision.
// - Bus-off is entered once clock and data lines have both been low without a break for two seconds.
// - Bus-off ends only when either bus line goes high, which the far end must cause.
// - After bus-off ends outside shutdown mode, the bus is usable again within 1 ms of the releasing edge.
// - Normal mode runs one processing cycle every 250 ms and idles in low power between cycles.
// - Sleep mode runs the same processing cycle at a programmable interval, low power between.
// - Sleep mode is left when current flow or a failure is detected.
// - Shutdown mode stops measurement, processing and bus answer; the register port and bus-off detection keep running.
// - Five temperature sources, one internal and four external, each have an enable and a cell/FET use select.
// - Two separately configurable thermistor models exist, one for cell and one for FET sensors.
// - When bus-off is entered in normal mode, an offset calibration runs and then sleep mode is entered.
package power_ctrl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int BUS_OFF_TIME_S = 2;
  localparam int BUS_OFF_CYCLES = BUS_OFF_TIME_S * CLK_HZ;
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYCLES = CLK_HZ / 1_000_000 * MS_TIME_US;
  localparam int RESUME_TIME_US = 1000;
  localparam int RESUME_CYCLES = CLK_HZ / 1_000_000 * RESUME_TIME_US;
  localparam int OFF_CNT_W = 26;
  localparam int MS_CNT_W = 15;
  localparam logic [15:0] NORMAL_PERIOD_MS = 16'h00FA;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLEEP_INT = 8'h04;
  localparam logic [7:0] OFS_TEMP_CFG = 8'h08;
  localparam logic [7:0] OFS_CELL_MODEL = 8'h0C;
  localparam logic [7:0] OFS_FET_MODEL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_INT_STATUS = 8'h18;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h1C;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h20;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  localparam int CTRL_SHUTDOWN_BIT = 0;
  localparam logic [15:0] SLEEP_INT_RST = 16'h03E8;
  localparam int NUM_TEMP = 5;
  localparam int TEMP_FET_LSB = 8;
  localparam logic [31:0] MODEL_RST = 32'h0000_0000;

  localparam int ST_NORMAL_BIT = 0;
  localparam int ST_SLEEP_BIT = 1;
  localparam int ST_SHUTDOWN_BIT = 2;
  localparam int ST_CALIB_BIT = 3;
  localparam int ST_BUS_OFF_BIT = 4;
  localparam int ST_BUS_ACTIVE_BIT = 5;

  localparam int NUM_EVT = 5;
  localparam int EVT_BUS_OFF = 0;
  localparam int EVT_BUS_ON = 1;
  localparam int EVT_WAKE = 2;
  localparam int EVT_CYCLE = 3;
  localparam int EVT_SLEEP = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_NORMAL, ST_CALIB, ST_SLEEP, ST_SHUTDOWN
  } mode_type;

  typedef struct packed {
    logic [NUM_TEMP-1:0] fet_sel;
    logic [NUM_TEMP-1:0] enable;
  } temp_cfg_type;

  typedef struct packed {
    logic [31:0] fet_model;
    logic [31:0] cell_model;
  } therm_models_type;

endpackage

// ==== design/interval_timer.sv ====
`timescale 1ns/1ps
module interval_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic restart,
  input wire logic [15:0] limit,
  output logic done
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic done_r;
  logic done_nxt;
  logic [15:0] lim;

  // A zero interval would wrap to 65536 ticks, so it counts as one tick
  always_comb begin
    lim = (limit == 16'h0000) ? 16'h0001 : limit;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (restart) begin
      cnt_nxt = 16'h0000;
    end else if (tick) begin
      if (cnt_r >= lim - 16'h0001) begin
        cnt_nxt = 16'h0000;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 16'h0000;
      done_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;

  // ****************************************
  // Checks
  // ****************************************
  interval_fire_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && tick && !restart && cnt_r == lim - 16'h0001 |=> done_r)
    else $error("interval did not fire at its limit");

endmodule

// ==== design/bus_idle_power_mode_control.sv ====
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module bus_idle_power_mode_control #(
  parameter int BUS_OFF_CYCLES = power_ctrl_pkg::BUS_OFF_CYCLES,
  parameter int MS_CYCLES = power_ctrl_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic bus_clock_pin,
  input wire logic bus_data_pin,
  input wire logic current_detect,
  input wire logic failure_detect,
  input wire logic calib_done,
  output logic cycle_start,
  output logic low_power,
  output logic calib_req,
  output logic bus_active,
  output power_ctrl_pkg::temp_cfg_type temp_cfg,
  output power_ctrl_pkg::therm_models_type therm_models,
  output logic irq
);

  localparam int NE = power_ctrl_pkg::NUM_EVT;

  // ****************************************
  // Bus slave
  // ****************************************
  logic acc;
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic [31:0] rd_val;
  logic hreadyout_r;
  logic hresp_r;

  logic [15:0] sleep_int_r;
  logic [15:0] sleep_int_nxt;
  power_ctrl_pkg::temp_cfg_type temp_cfg_r;
  power_ctrl_pkg::temp_cfg_type temp_cfg_nxt;
  power_ctrl_pkg::therm_models_type models_r;
  power_ctrl_pkg::therm_models_type models_nxt;
  logic [NE-1:0] int_sts_r;
  logic [NE-1:0] int_sts_nxt;
  logic [NE-1:0] int_en_r;
  logic [NE-1:0] int_en_nxt;
  logic [NE-1:0] int_clr;
  logic [NE-1:0] evt;
  logic irq_r;
  logic shutdown_wr;
  logic [31:0] status_val;

  power_ctrl_pkg::mode_type mode_r;
  power_ctrl_pkg::mode_type mode_nxt;
  logic bus_off_r;
  logic bus_off_nxt;

  assign acc = hsel && htrans[1] && hready && hsize == power_ctrl_pkg::SIZE_WORD;

  always_comb begin
    status_val = power_ctrl_pkg::READ_ZERO;
    status_val[power_ctrl_pkg::ST_NORMAL_BIT] =
      mode_r == power_ctrl_pkg::ST_NORMAL;
    status_val[power_ctrl_pkg::ST_SLEEP_BIT] =
      mode_r == power_ctrl_pkg::ST_SLEEP;
    status_val[power_ctrl_pkg::ST_SHUTDOWN_BIT] =
      mode_r == power_ctrl_pkg::ST_SHUTDOWN;
    status_val[power_ctrl_pkg::ST_CALIB_BIT] =
      mode_r == power_ctrl_pkg::ST_CALIB;
    status_val[power_ctrl_pkg::ST_BUS_OFF_BIT] = bus_off_r;
    status_val[power_ctrl_pkg::ST_BUS_ACTIVE_BIT] = bus_active;
    rd_val = power_ctrl_pkg::READ_ZERO;
    unique case (haddr[7:0])
      power_ctrl_pkg::OFS_SLEEP_INT: rd_val[15:0] = sleep_int_r;
      power_ctrl_pkg::OFS_TEMP_CFG: begin
        rd_val[power_ctrl_pkg::NUM_TEMP-1:0] = temp_cfg_r.enable;
        rd_val[power_ctrl_pkg::TEMP_FET_LSB +: power_ctrl_pkg::NUM_TEMP] =
          temp_cfg_r.fet_sel;
      end
      power_ctrl_pkg::OFS_CELL_MODEL: rd_val = models_r.cell_model;
      power_ctrl_pkg::OFS_FET_MODEL: rd_val = models_r.fet_model;
      power_ctrl_pkg::OFS_STATUS: rd_val = status_val;
      power_ctrl_pkg::OFS_INT_STATUS: rd_val[NE-1:0] = int_sts_r;
      power_ctrl_pkg::OFS_INT_ENABLE: rd_val[NE-1:0] = int_en_r;
      default: rd_val = power_ctrl_pkg::READ_ZERO;
    endcase
    wr_pend_nxt = acc && hwrite;
    wr_addr_nxt = acc ? haddr[7:0] : wr_addr_r;
    hrdata_nxt = (acc && !hwrite) ? rd_val : hrdata_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else if (ce) begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ****************************************
  // Registers and interrupt
  // ****************************************
  always_comb begin
    sleep_int_nxt = sleep_int_r;
    temp_cfg_nxt = temp_cfg_r;
    models_nxt = models_r;
    int_en_nxt = int_en_r;
    int_clr = '0;
    shutdown_wr = 1'b0;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        power_ctrl_pkg::OFS_CTRL:
          shutdown_wr = hwdata[power_ctrl_pkg::CTRL_SHUTDOWN_BIT];
        power_ctrl_pkg::OFS_SLEEP_INT: sleep_int_nxt = hwdata[15:0];
        power_ctrl_pkg::OFS_TEMP_CFG: begin
          temp_cfg_nxt.enable = hwdata[power_ctrl_pkg::NUM_TEMP-1:0];
          temp_cfg_nxt.fet_sel =
            hwdata[power_ctrl_pkg::TEMP_FET_LSB +: power_ctrl_pkg::NUM_TEMP];
        end
        power_ctrl_pkg::OFS_CELL_MODEL: models_nxt.cell_model = hwdata;
        power_ctrl_pkg::OFS_FET_MODEL: models_nxt.fet_model = hwdata;
        power_ctrl_pkg::OFS_INT_CLEAR: int_clr = hwdata[NE-1:0];
        power_ctrl_pkg::OFS_INT_ENABLE: int_en_nxt = hwdata[NE-1:0];
        default: int_clr = '0;
      endcase
    end
    // A new event in the clearing cycle survives the clear
    int_sts_nxt = (int_sts_r & ~int_clr) | evt;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_int_r <= power_ctrl_pkg::SLEEP_INT_RST;
      temp_cfg_r <= '0;
      models_r <= {power_ctrl_pkg::MODEL_RST, power_ctrl_pkg::MODEL_RST};
      int_sts_r <= '0;
      int_en_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      sleep_int_r <= sleep_int_nxt;
      temp_cfg_r <= temp_cfg_nxt;
      models_r <= models_nxt;
      int_sts_r <= int_sts_nxt;
      int_en_r <= int_en_nxt;
      irq_r <= |(int_sts_r & int_en_r);
    end
  end

  // ****************************************
  // Bus-off detection
  // ****************************************
  logic [power_ctrl_pkg::OFF_CNT_W-1:0] off_cnt_r;
  logic [power_ctrl_pkg::OFF_CNT_W-1:0] off_cnt_nxt;
  logic line_high;

  assign line_high = bus_clock_pin || bus_data_pin;

  always_comb begin
    off_cnt_nxt = off_cnt_r;
    bus_off_nxt = bus_off_r;
    if (line_high) begin
      off_cnt_nxt = '0;
      bus_off_nxt = 1'b0;
    end else if (!bus_off_r) begin
      if (off_cnt_r == BUS_OFF_CYCLES[power_ctrl_pkg::OFF_CNT_W-1:0] - 1'b1) begin
        bus_off_nxt = 1'b1;
      end else begin
        off_cnt_nxt = off_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      off_cnt_r <= '0;
      bus_off_r <= 1'b0;
    end else if (ce) begin
      off_cnt_r <= off_cnt_nxt;
      bus_off_r <= bus_off_nxt;
    end
  end

  // ****************************************
  // Power modes
  // ****************************************
  logic [power_ctrl_pkg::MS_CNT_W-1:0] ms_cnt_r;
  logic [power_ctrl_pkg::MS_CNT_W-1:0] ms_cnt_nxt;
  logic ms_tick_r;
  logic ms_tick_nxt;
  logic running;
  logic tmr_done;
  logic cycle_r;
  logic cycle_nxt;
  logic calib_req_r;
  logic calib_req_nxt;
  logic low_power_r;
  logic bus_active_r;
  logic bus_active_nxt;

  assign running = mode_r == power_ctrl_pkg::ST_NORMAL ||
    mode_r == power_ctrl_pkg::ST_SLEEP;

  interval_timer u_interval (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .tick(ms_tick_r),
    .restart(mode_nxt != mode_r),
    .limit(mode_r == power_ctrl_pkg::ST_SLEEP ? sleep_int_r :
      power_ctrl_pkg::NORMAL_PERIOD_MS),
    .done(tmr_done)
  );

  always_comb begin
    mode_nxt = mode_r;
    calib_req_nxt = 1'b0;
    unique case (mode_r)
      power_ctrl_pkg::ST_NORMAL: begin
        if (shutdown_wr) begin
          mode_nxt = power_ctrl_pkg::ST_SHUTDOWN;
        end else if (bus_off_nxt && !bus_off_r) begin
          mode_nxt = power_ctrl_pkg::ST_CALIB;
          calib_req_nxt = 1'b1;
        end
      end
      power_ctrl_pkg::ST_CALIB: begin
        if (shutdown_wr) begin
          mode_nxt = power_ctrl_pkg::ST_SHUTDOWN;
        end else if (calib_done) begin
          mode_nxt = power_ctrl_pkg::ST_SLEEP;
        end
      end
      power_ctrl_pkg::ST_SLEEP: begin
        if (shutdown_wr) begin
          mode_nxt = power_ctrl_pkg::ST_SHUTDOWN;
        end else if (current_detect || failure_detect) begin
          mode_nxt = power_ctrl_pkg::ST_NORMAL;
        end
      end
      power_ctrl_pkg::ST_SHUTDOWN: mode_nxt = power_ctrl_pkg::ST_SHUTDOWN;
    endcase
    // Prescaler idles outside the cycling modes to save power
    ms_tick_nxt = 1'b0;
    ms_cnt_nxt = '0;
    if (running && mode_nxt != power_ctrl_pkg::ST_SHUTDOWN) begin
      if (ms_cnt_r == MS_CYCLES[power_ctrl_pkg::MS_CNT_W-1:0] - 1'b1) begin
        ms_tick_nxt = 1'b1;
      end else begin
        ms_cnt_nxt = ms_cnt_r + 1'b1;
      end
    end
    cycle_nxt = tmr_done && running && mode_nxt == mode_r;
    // Bus engine of the v1.1 interface is only enabled here
    bus_active_nxt = !bus_off_nxt &&
      mode_nxt != power_ctrl_pkg::ST_SHUTDOWN;
    evt = '0;
    evt[power_ctrl_pkg::EVT_BUS_OFF] = bus_off_nxt && !bus_off_r;
    evt[power_ctrl_pkg::EVT_BUS_ON] = !bus_off_nxt && bus_off_r;
    evt[power_ctrl_pkg::EVT_WAKE] = mode_r == power_ctrl_pkg::ST_SLEEP &&
      mode_nxt == power_ctrl_pkg::ST_NORMAL;
    evt[power_ctrl_pkg::EVT_CYCLE] = cycle_nxt;
    evt[power_ctrl_pkg::EVT_SLEEP] = mode_r != power_ctrl_pkg::ST_SLEEP &&
      mode_nxt == power_ctrl_pkg::ST_SLEEP;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= power_ctrl_pkg::ST_NORMAL;
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
      cycle_r <= 1'b0;
      calib_req_r <= 1'b0;
      low_power_r <= 1'b1;
      bus_active_r <= 1'b1;
    end else if (ce) begin
      mode_r <= mode_nxt;
      ms_cnt_r <= ms_cnt_nxt;
      ms_tick_r <= ms_tick_nxt;
      cycle_r <= cycle_nxt;
      calib_req_r <= calib_req_nxt;
      low_power_r <= !cycle_nxt;
      bus_active_r <= bus_active_nxt;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign cycle_start = cycle_r;
  assign low_power = low_power_r;
  assign calib_req = calib_req_r;
  assign bus_active = bus_active_r;
  assign temp_cfg = temp_cfg_r;
  assign therm_models = models_r;
  assign irq = irq_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  bus_off_entry_a: assert property (
    $rose(bus_off_r) |-> $past(!line_high) &&
      $past(off_cnt_r) == BUS_OFF_CYCLES - 1)
    else $error("bus-off entered before the full low time");
  bus_off_exit_a: assert property (
    ce && bus_off_r && line_high |=> !bus_off_r)
    else $error("bus-off not left on a high line");
  bus_off_hold_a: assert property (
    ce && bus_off_r && !line_high |=> bus_off_r)
    else $error("bus-off left while both lines low");
  count_restart_a: assert property (
    ce && line_high |=> off_cnt_r == 0)
    else $error("bus-off count not restarted");
  bus_resume_a: assert property (
    $fell(bus_off_r) && mode_r != power_ctrl_pkg::ST_SHUTDOWN |-> bus_active_r)
    else $error("bus not usable after bus-off release");
  shutdown_quiet_a: assert property (
    mode_r == power_ctrl_pkg::ST_SHUTDOWN |-> !cycle_r && !bus_active_r &&
      !ms_tick_r ##1 mode_r == power_ctrl_pkg::ST_SHUTDOWN)
    else $error("activity in shutdown");
  sleep_wake_a: assert property (
    ce && mode_r == power_ctrl_pkg::ST_SLEEP && !shutdown_wr &&
      (current_detect || failure_detect) |=> mode_r == power_ctrl_pkg::ST_NORMAL)
    else $error("no wake from sleep");
  calib_seq_a: assert property (
    ce && mode_r == power_ctrl_pkg::ST_NORMAL && !shutdown_wr &&
      $rose(bus_off_nxt) |=> calib_req_r && mode_r == power_ctrl_pkg::ST_CALIB)
    else $error("bus-off did not start calibration");
  cycle_power_a: assert property (
    cycle_r |-> !low_power_r && $past(running))
    else $error("processing cycle outside cycling mode");
  temp_cfg_a: assert property (
    ce && wr_pend_r && wr_addr_r == power_ctrl_pkg::OFS_TEMP_CFG
      |=> temp_cfg.enable == $past(hwdata[power_ctrl_pkg::NUM_TEMP-1:0]))
    else $error("temperature enables not written");

  wake_cycle_c: cover property (
    mode_r == power_ctrl_pkg::ST_SLEEP ##1 mode_r == power_ctrl_pkg::ST_NORMAL);
  calib_sleep_c: cover property (
    mode_r == power_ctrl_pkg::ST_CALIB ##1 mode_r == power_ctrl_pkg::ST_SLEEP);
  bus_release_c: cover property ($fell(bus_off_r));
  irq_c: cover property ($rose(irq_r));

endmodule

// ==== dv/bus_line_model.sv ====
`timescale 1ns/1ps
module bus_line_model (
  input wire logic clk,
  input wire logic [1:0] lines_up,
  output logic bus_clock_pin,
  output logic bus_data_pin
);
  // ****************************************
  // Far-end line drive
  // ****************************************
  // The host idles both lines high.
  // A line it lets go falls to the internal pull-down level.
  initial begin
    bus_clock_pin = 1'b1;
    bus_data_pin = 1'b1;
  end

  // Lines change only after a clock edge, never mid-cycle
  always @(posedge clk) begin
    bus_clock_pin <= lines_up[0];
    bus_data_pin <= lines_up[1];
  end
endmodule

// ==== dv/bus_idle_power_mode_control_test.sv ====
`timescale 1ns/1ps
module bus_idle_power_mode_control_test;
  // Short counts keep the run brief
  localparam int OFF_N = 20;
  localparam int MS_N = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic current_detect = 1'b0;
  logic failure_detect = 1'b0;
  logic calib_done = 1'b0;
  logic ce = 1'b1;
  logic [1:0] lines_up = 2'h3;
  logic hreadyout, hresp, bus_clock_pin, bus_data_pin;
  logic cycle_start, low_power, calib_req, bus_active, irq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  power_ctrl_pkg::temp_cfg_type temp_cfg;
  power_ctrl_pkg::therm_models_type therm_models;
  int n_errors = 0;
  int cmp_count = 0;

  bus_idle_power_mode_control #(.BUS_OFF_CYCLES(OFF_N), .MS_CYCLES(MS_N))
    dut_u (.clk(clk), .reset_n(reset_n), .ce(ce), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .bus_clock_pin(bus_clock_pin),
    .bus_data_pin(bus_data_pin), .current_detect(current_detect),
    .failure_detect(failure_detect), .calib_done(calib_done),
    .cycle_start(cycle_start), .low_power(low_power),
    .calib_req(calib_req), .bus_active(bus_active), .temp_cfg(temp_cfg),
    .therm_models(therm_models), .irq(irq));

  bus_line_model far_u (.clk(clk), .lines_up(lines_up),
    .bus_clock_pin(bus_clock_pin), .bus_data_pin(bus_data_pin));

  initial begin
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single word transfer; no fixed latency is assumed
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask

  // Counts falling edges up to the next processing pulse
  task automatic next_pulse(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cycle_start !== 1'b1 && n < 5000);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_values;
    chk("hreadyout", hreadyout, 32'h1);
    chk("hresp", hresp, 32'h0);
    chk("bus_active", bus_active, 32'h1);
    chk("temp_cfg", temp_cfg, 32'h0);
    chk("irq", irq, 32'h0);
    rdchk("sleep_int", power_ctrl_pkg::OFS_SLEEP_INT, 32'h3E8);
    rdchk("status", power_ctrl_pkg::OFS_STATUS, 32'h21);
    rdchk("unmapped", 8'h40, 32'h0);
  endtask

  task automatic temp_config;
    ahb(1'b1, power_ctrl_pkg::OFS_TEMP_CFG, 32'h0000_1305);
    ahb(1'b1, power_ctrl_pkg::OFS_CELL_MODEL, 32'hA5A5_0001);
    ahb(1'b1, power_ctrl_pkg::OFS_FET_MODEL, 32'h5A5A_0002);
    @(negedge clk);
    chk("temp_cfg", temp_cfg, {5'h13, 5'h05});
    chk("fet_model", therm_models.fet_model, 32'h5A5A_0002);
    chk("cell_model", therm_models.cell_model, 32'hA5A5_0001);
    @(posedge clk);
    rdchk("temp_rd", power_ctrl_pkg::OFS_TEMP_CFG, 32'h1305);
  endtask

  task automatic normal_period;
    int n;
    next_pulse(n);
    next_pulse(n);
    chk("normal_period", n, 250 * MS_N);
    chk("low_power_pulse", low_power, 32'h0);
    @(negedge clk);
    chk("low_power_gap", low_power, 32'h1);
    // Ten frozen edges push the pulse out; counting starts 11 edges late
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    next_pulse(n);
    chk("ce_freeze", n, 250 * MS_N - 1);
  endtask

  // A one-cycle high blip must restart the idle count
  task automatic enter_sleep;
    int n;
    logic seen_cal;
    lines_up <= 2'h0;
    repeat (15) @(posedge clk);
    lines_up <= 2'h1;
    @(posedge clk);
    lines_up <= 2'h0;
    n = 0;
    seen_cal = 1'b0;
    do begin
      @(negedge clk);
      n++;
      seen_cal = seen_cal | (calib_req === 1'b1);
    end while (bus_active === 1'b1 && n < 100);
    chk("bus_off_time", n >= OFF_N - 1 && n <= OFF_N + 4, 32'h1);
    chk("calib_req", seen_cal, 32'h1);
    @(posedge clk);
    rdchk("status_calib", power_ctrl_pkg::OFS_STATUS, 32'h18);
    calib_done <= 1'b1;
    @(posedge clk);
    calib_done <= 1'b0;
    rdchk("status_sleep", power_ctrl_pkg::OFS_STATUS, 32'h12);
    next_pulse(n);
    next_pulse(n);
    chk("sleep_period", n, 2 * MS_N);
    @(posedge clk);
    lines_up <= 2'h2;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bus_active !== 1'b1 && n < power_ctrl_pkg::RESUME_CYCLES);
    chk("resume_time", n < power_ctrl_pkg::RESUME_CYCLES, 32'h1);
    @(posedge clk);
    rdchk("status_back", power_ctrl_pkg::OFS_STATUS, 32'h22);
  endtask

  // Each wake source is tried from a fresh entry into sleep
  task automatic wake_test;
    for (int i = 0; i < 2; i++) begin
      enter_sleep();
      if (i == 0)
        current_detect <= 1'b1;
      else
        failure_detect <= 1'b1;
      @(posedge clk);
      current_detect <= 1'b0;
      failure_detect <= 1'b0;
      rdchk("status_wake", power_ctrl_pkg::OFS_STATUS, 32'h21);
      ahb(1'b0, power_ctrl_pkg::OFS_INT_STATUS, 32'h0000_0000);
      chk("wake_event", rd[power_ctrl_pkg::EVT_WAKE], 32'h1);
    end
  endtask

  task automatic irq_test;
    chk("irq_masked", irq, 32'h0);
    ahb(1'b1, power_ctrl_pkg::OFS_INT_ENABLE, 32'h0000_0004);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq_on", irq, 32'h1);
    @(posedge clk);
    rdchk("int_enable", power_ctrl_pkg::OFS_INT_ENABLE, 32'h4);
    ahb(1'b1, power_ctrl_pkg::OFS_INT_CLEAR, 32'h0000_0004);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq_cleared", irq, 32'h0);
  endtask

  task automatic shutdown_test;
    int n;
    @(posedge clk);
    ahb(1'b1, power_ctrl_pkg::OFS_CTRL, 32'h0000_0001);
    rdchk("status_off", power_ctrl_pkg::OFS_STATUS, 32'h04);
    n = 0;
    repeat (1100) begin
      @(negedge clk);
      n = n + (cycle_start === 1'b1);
    end
    chk("off_cycles", n, 32'h0);
    chk("off_bus", bus_active, 32'h0);
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    reset_values();
    temp_config();
    ahb(1'b1, power_ctrl_pkg::OFS_SLEEP_INT, 32'h0000_0002);
    normal_period();
    wake_test();
    irq_test();
    shutdown_test();
    complete_run();
  end

  // Whole plan needs under 6000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule
